// ---- shared/dcr_if.sv ----
// pin bundle between the cache controller and the data ram
`timescale 1ns/100ps
`default_nettype none
interface dcr_if;
	import dcr_pkg::*;
	logic [ADDR_HI:ADDR_LO] word_addr;
	logic [LOW_W-1:0] bank0_low;
	logic [WORD_W-1:0] wdata;
	logic [LANES-1:0] lane_we;
	logic [SETS-1:0] set_choose;
	logic bypass;
	logic enable;
	logic test_mode;
	logic [ADDR_W-1:0] bist_addr;
	logic [WORD_W-1:0] bist_wdata;
	logic [LANES-1:0] bist_we;
	logic bist_enable;
	logic scan_in;
	logic scan_shift_control;
	logic [WORD_W-1:0] rd_data;
	logic [HALF_W-1:0] lane0_raw_read;
	logic [HALF_W-1:0] lane1_raw_read;
	logic scan_out;
	modport dev (
		input word_addr, bank0_low, wdata, lane_we, set_choose, bypass,
		input enable, test_mode, bist_addr, bist_wdata, bist_we,
		input bist_enable, scan_in, scan_shift_control,
		output rd_data, lane0_raw_read, lane1_raw_read, scan_out
	);
	modport ctl (
		output word_addr, bank0_low, wdata, lane_we, set_choose, bypass,
		output enable, test_mode, bist_addr, bist_wdata, bist_we,
		output bist_enable, scan_in, scan_shift_control,
		input rd_data, lane0_raw_read, lane1_raw_read, scan_out
	);
endinterface : dcr_if
`default_nettype wire

// ---- shared/dcr_pkg.sv ----
// constants shared by the data ram, its controller and their interface
package dcr_pkg;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 2;
	localparam int ADDR_W = 11;
	localparam int B0_KEEP_LO = 4;
	localparam int SWAP_BIT = 0;
	localparam int LOW_W = 2;
	localparam int HALF_W = 32;
	localparam int WORD_W = 64;
	localparam int LANES = 4;
	localparam int SETS = 2;
	localparam int DEPTH = 2048;
	localparam int SCAN_LEN = 8;
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WLO = 8'h08;
	localparam logic [7:0] OFS_WHI = 8'h0c;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_RLO = 8'h14;
	localparam logic [7:0] OFS_RHI = 8'h18;
	localparam logic [7:0] OFS_RAW0 = 8'h1c;
	localparam logic [7:0] OFS_RAW1 = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_BYPASS = 1;
	localparam int CTRL_TEST = 2;
	localparam int CTRL_BIST_EN = 3;
	localparam int CTRL_SCAN_SH = 4;
	localparam int CTRL_SCAN_IN = 5;
	localparam int CTRL_SET_LO = 8;
	localparam int STAT_SCAN_OUT = 0;
	localparam logic [31:0] CTRL_MASK = 32'h0000_033f;
	localparam logic [31:0] ADDR_MASK = 32'h0000_1fff;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dcr_pkg

// ---- verif/dcr_chk.sv ----
// pin-level assertions between the cache controller and the data ram
`timescale 1ns/100ps
`default_nettype none
module dcr_chk
	import dcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_HI:ADDR_LO] word_addr,
	input wire logic [WORD_W-1:0] wdata,
	input wire logic [LANES-1:0] lane_we,
	input wire logic bypass,
	input wire logic enable,
	input wire logic test_mode,
	input wire logic [ADDR_W-1:0] bist_addr,
	input wire logic [WORD_W-1:0] bist_wdata,
	input wire logic bist_enable,
	input wire logic scan_in,
	input wire logic scan_shift_control,
	input wire logic [WORD_W-1:0] rd_data,
	input wire logic [HALF_W-1:0] lane0_raw_read,
	input wire logic [HALF_W-1:0] lane1_raw_read,
	input wire logic scan_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic eff;
	logic [WORD_W-1:0] ab, ba;
	assign eff = test_mode ? bist_enable : enable;
	// raw words are the only view of each bank before the swap
	assign ab = {lane0_raw_read, lane1_raw_read};
	assign ba = {lane1_raw_read, lane0_raw_read};
	a_hold_normal: assert property (
		!test_mode && !enable && !bypass |=> $stable(rd_data))
		else $error("rd_data moved while disabled");
	a_hold_test: assert property (
		test_mode && !bist_enable && !bypass |=> $stable(rd_data))
		else $error("rd_data moved while self-test disabled");
	a_raw_hold: assert property (
		!eff && !bypass |=> $stable(lane0_raw_read) && $stable(lane1_raw_read))
		else $error("raw outputs moved while disabled");
	a_bypass_word: assert property (
		bypass |=> rd_data == ($past(test_mode) ? $past(bist_wdata)
		: $past(wdata)))
		else $error("bypass word not on rd_data");
	// array is not reset: an unwritten word must match bit for bit
	a_read_swap: assert property (
		eff && !bypass && !test_mode |=>
		rd_data === ($past(word_addr[2]) ? ab : ba))
		else $error("way order wrong on rd_data");
	a_test_swap: assert property (
		test_mode && bist_enable && !bypass |=>
		rd_data === ($past(bist_addr[0]) ? ab : ba))
		else $error("self-test way order wrong");
	a_scan_shift: assert property (
		scan_shift_control [*8] |=> scan_out == $past(scan_in, 8))
		else $error("scan chain length or order wrong");
	a_lane_pulse: assert property (
		lane_we != '0 |=> lane_we == '0)
		else $error("lane write longer than one cycle");
	c_bypass: cover property (bypass && !enable);
	c_selftest: cover property (test_mode && bist_enable);
	c_write: cover property (lane_we == 4'hf && enable);
endmodule : dcr_chk
`default_nettype wire

// ---- verif/dcr_data_ram_port_bench.sv ----
// bench joining the cache controller and the data ram over their pins
`timescale 1ns/100ps
`default_nettype none
module dcr_data_ram_port_bench;
	import dcr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdat = 32'h0, rdata, got;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic act, tst, byp;
	int error_cnt = 0;
	int comparisons = 0;
	dcr_if link ();
	always #12.5 aclk = ~aclk;
	dcr_data_ram u_dcr_data_ram (.aclk(aclk), .aresetn(aresetn), .link(link),
		.array_active(act), .selftest_active(tst), .bypass_active(byp));
	// ready lines held high: every answer is taken on its first cycle
	dcr_cache_ctl u_dcr_cache_ctl (.aclk(aclk), .aresetn(aresetn),
		.link(link), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));
	dcr_chk u_dcr_chk (.aclk(aclk), .aresetn(aresetn),
		.word_addr(link.word_addr), .wdata(link.wdata),
		.lane_we(link.lane_we), .bypass(link.bypass), .enable(link.enable),
		.test_mode(link.test_mode), .bist_addr(link.bist_addr),
		.bist_wdata(link.bist_wdata), .bist_enable(link.bist_enable),
		.scan_in(link.scan_in), .scan_shift_control(link.scan_shift_control),
		.rd_data(link.rd_data), .lane0_raw_read(link.lane0_raw_read),
		.lane1_raw_read(link.lane1_raw_read), .scan_out(link.scan_out));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// readies are sampled mid-cycle, where they are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		b = 1'b0;
		awaddr <= a;
		wdat <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			b = bvalid === 1'b1;
			rsp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta, r;
		r = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!r) begin
			@(negedge aclk);
			ta = arvalid && arready === 1'b1;
			r = rvalid === 1'b1;
			got = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), got, e);
	endtask : rc
	task automatic put(input logic [31:0] ad, lo, hi, input logic [3:0] ln);
		wr(OFS_ADDR, ad);
		wr(OFS_WLO, lo);
		wr(OFS_WHI, hi);
		wr(OFS_CMD, {28'h0, ln});
		// read-first ram: the new word shows one edge later
		@(posedge aclk);
	endtask : put
	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4000) @(posedge aclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(OFS_CTRL, CTRL_RESET);
		rc(OFS_RLO, ZERO_WORD);
		rc(OFS_STAT, ZERO_WORD);
		rd(8'h28);
		chk("unmapped read", {got[31:2], rsp}, {30'h0, RESP_SLVERR});
		wr(8'h28, 32'h1);
		chk("unmapped write", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(OFS_CTRL, 32'h301);
		put(32'h120, 32'ha0a1a2a3, 32'hb0b1b2b3, 4'hf);
		rc(OFS_RLO, 32'ha0a1a2a3);
		rc(OFS_RHI, 32'hb0b1b2b3);
		rc(OFS_RAW0, 32'ha0a1a2a3);
		rc(OFS_RAW1, 32'hb0b1b2b3);
		// odd word with low field 01 so both banks hit one index
		put(32'h125, 32'hc0c1c2c3, 32'hd0d1d2d3, 4'hf);
		rc(OFS_RLO, 32'hd0d1d2d3);
		rc(OFS_RHI, 32'hc0c1c2c3);
		wr(OFS_ADDR, 32'h121);
		rc(OFS_RLO, 32'hc0c1c2c3);
		rc(OFS_RHI, 32'hb0b1b2b3);
		wr(OFS_CTRL, 32'h101);
		put(32'h120, 32'hffffffff, 32'hffffffff, 4'h2);
		rc(OFS_RLO, 32'ha0a1ffa3);
		rc(OFS_RHI, 32'hb0b1b2b3);
		wr(OFS_CTRL, 32'h300);
		put(32'h125, 32'h0, 32'h0, 4'hf);
		rc(OFS_RLO, 32'ha0a1ffa3);
		rc(OFS_RAW1, 32'hb0b1b2b3);
		wr(OFS_CTRL, 32'h302);
		wr(OFS_WLO, 32'h5a5a5a5a);
		wr(OFS_WHI, 32'h3c3c3c3c);
		rc(OFS_RLO, 32'h5a5a5a5a);
		rc(OFS_RHI, 32'h3c3c3c3c);
		rc(OFS_RAW0, 32'ha0a1ffa3);
		chk("mode flags", {29'h0, byp, tst, act}, 32'h4);
		wr(OFS_CTRL, 32'h301);
		rc(OFS_RLO, 32'hd0d1d2d3);
		chk("mode flags", {29'h0, byp, tst, act}, 32'h1);
		// normal enable low: only the self-test enable may open the ram
		wr(OFS_CTRL, 32'h30c);
		put(32'h120, 32'h0f0e0d0c, 32'h1f1e1d1c, 4'hf);
		wr(OFS_CTRL, 32'h301);
		rc(OFS_RLO, 32'h0f0e0d0c);
		rc(OFS_RHI, 32'h1f1e1d1c);
		wr(OFS_CTRL, 32'h305);
		wr(OFS_ADDR, 32'h125);
		rc(OFS_RLO, 32'h0f0e0d0c);
		chk("mode flags", {29'h0, byp, tst, act}, 32'h2);
		wr(OFS_CTRL, 32'h301);
		rc(OFS_RLO, 32'hd0d1d2d3);
		wr(OFS_CTRL, 32'h030);
		repeat (SCAN_LEN) @(posedge aclk);
		rc(OFS_STAT, 32'h1);
		wr(OFS_CTRL, 32'h010);
		repeat (SCAN_LEN) @(posedge aclk);
		rc(OFS_STAT, 32'h0);
		tally_and_finish();
	end
endmodule : dcr_data_ram_port_bench
`default_nettype wire

// ---- verilog/dcr_bank.sv ----
// one 2048 x 32 bank with byte-lane writes and a combinational read port
`timescale 1ns/100ps
`default_nettype none
module dcr_bank
	import dcr_pkg::*;
(
	input wire logic aclk,
	input wire logic [LANES-1:0] wr_lanes,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [HALF_W-1:0] wdata,
	output logic [HALF_W-1:0] rdata
);
	logic [HALF_W-1:0] mem [DEPTH];

	// read returns the old word; the caller registers it on the same edge
	assign rdata = mem[addr];

	// lane 0 is the least significant byte
	always_ff @(posedge aclk) begin
		for (int i = 0; i < LANES; i++) begin
			if (wr_lanes[i]) begin
				mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
			end
		end
	end
endmodule : dcr_bank
`default_nettype wire

// ---- verilog/dcr_cache_ctl.sv ----
// cache controller end: axi4-lite registers drive the data ram pins
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module dcr_cache_ctl
	import dcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	dcr_if.ctl link,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] ctrl_reg, ctrl_next, addr_reg, addr_next;
	logic [31:0] wlo_reg, wlo_next, whi_reg, whi_next;
	logic [LANES-1:0] lanes_reg, lanes_next;
	logic go_reg, go_next;
	logic do_write;

	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		addr_next = addr_reg;
		wlo_next = wlo_reg;
		whi_next = whi_reg;
		lanes_next = lanes_reg;
		go_next = 1'b0;
		if (s_axi_awvalid && !aw_hold_reg) begin
			aw_hold_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold_reg) begin
			w_hold_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			case (awaddr_reg)
			OFS_CTRL: ctrl_next = merge(ctrl_reg, wd_reg, ws_reg) & CTRL_MASK;
			OFS_ADDR: addr_next = merge(addr_reg, wd_reg, ws_reg) & ADDR_MASK;
			OFS_WLO: wlo_next = merge(wlo_reg, wd_reg, ws_reg);
			OFS_WHI: whi_next = merge(whi_reg, wd_reg, ws_reg);
			OFS_CMD: begin
				// one access cycle; lane bits zero give a plain read
				lanes_next = ws_reg[0] ? wd_reg[LANES-1:0] : '0;
				go_next = 1'b1;
			end
			OFS_RLO, OFS_RHI, OFS_RAW0, OFS_RAW1, OFS_STAT: begin
				bresp_next = RESP_OKAY;
			end
			default: bresp_next = RESP_SLVERR;
			endcase
		end
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (s_axi_araddr)
			OFS_CTRL: rdata_next = ctrl_reg;
			OFS_ADDR: rdata_next = addr_reg;
			OFS_WLO: rdata_next = wlo_reg;
			OFS_WHI: rdata_next = whi_reg;
			OFS_CMD: rdata_next = {28'h0000000, lanes_reg};
			OFS_RLO: rdata_next = link.rd_data[HALF_W-1:0];
			OFS_RHI: rdata_next = link.rd_data[WORD_W-1:HALF_W];
			OFS_RAW0: rdata_next = link.lane0_raw_read;
			OFS_RAW1: rdata_next = link.lane1_raw_read;
			OFS_STAT: rdata_next = {31'h00000000, link.scan_out};
			default: begin
				rdata_next = ZERO_WORD;
				rresp_next = RESP_SLVERR;
			end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wd_reg <= '0;
			ws_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= ZERO_WORD;
			ctrl_reg <= CTRL_RESET;
			addr_reg <= ZERO_WORD;
			wlo_reg <= ZERO_WORD;
			whi_reg <= ZERO_WORD;
			lanes_reg <= '0;
			go_reg <= 1'b0;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			addr_reg <= addr_next;
			wlo_reg <= wlo_next;
			whi_reg <= whi_next;
			lanes_reg <= lanes_next;
			go_reg <= go_next;
		end
	end

	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready = !w_hold_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign link.word_addr = addr_reg[ADDR_HI:ADDR_LO];
	assign link.bank0_low = addr_reg[LOW_W-1:0];
	assign link.wdata = {whi_reg, wlo_reg};
	assign link.lane_we = (go_reg && !ctrl_reg[CTRL_TEST]) ? lanes_reg : '0;
	assign link.bist_we = (go_reg && ctrl_reg[CTRL_TEST]) ? lanes_reg : '0;
	assign link.set_choose = ctrl_reg[CTRL_SET_LO +: SETS];
	assign link.bypass = ctrl_reg[CTRL_BYPASS];
	assign link.enable = ctrl_reg[CTRL_ENABLE];
	assign link.test_mode = ctrl_reg[CTRL_TEST];
	assign link.bist_enable = ctrl_reg[CTRL_BIST_EN];
	assign link.bist_addr = addr_reg[ADDR_HI:ADDR_LO];
	assign link.bist_wdata = {whi_reg, wlo_reg};
	assign link.scan_shift_control = ctrl_reg[CTRL_SCAN_SH];
	assign link.scan_in = ctrl_reg[CTRL_SCAN_IN];
endmodule : dcr_cache_ctl
`default_nettype wire

// ---- verilog/dcr_data_ram.sv ----
// two-bank data cache data ram with bypass, power-down, self-test and scan
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - bank 1 location is address bits 12:2
// - bank 0 uses bits 12:4 plus low field
// - upper write half to bank 1, lower to 0
// - four byte-lane write enables, active high
// - two set-choose bits, high selects a set
// - bypass routes write word, even when disabled
// - enable low holds raw outputs, and rd_data unless bypass
// - test mode takes self-test inputs instead
// - self-test enable acts as enable in test
// - read output: set 1 upper, set 0 lower
// - raw bank outputs before bypass and swap
// - scan chain with in, control and out
// - address bit 2 swaps ways between banks
// - bypass overrides both output halves
// - each bank holds 2048 words of 32 bits
module dcr_data_ram
	import dcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	dcr_if.dev link,
	output logic array_active,
	output logic selftest_active,
	output logic bypass_active
);
	logic test_sel;
	logic eff_enable;
	logic odd_word;
	logic [ADDR_W-1:0] b0_addr;
	logic [ADDR_W-1:0] b1_addr;
	logic [WORD_W-1:0] wword;
	logic [LANES-1:0] lanes;
	logic b0_way;
	logic b1_way;
	logic [LANES-1:0] b0_we;
	logic [LANES-1:0] b1_we;
	logic [HALF_W-1:0] b0_rd;
	logic [HALF_W-1:0] b1_rd;
	logic b0_set_on;
	logic b1_set_on;
	logic [HALF_W-1:0] set0_word;
	logic [HALF_W-1:0] set1_word;
	logic [SCAN_LEN-1:0] scan_cap;

	logic [WORD_W-1:0] rd_out_reg;
	logic [WORD_W-1:0] rd_out_next;
	logic [HALF_W-1:0] raw0_reg;
	logic [HALF_W-1:0] raw0_next;
	logic [HALF_W-1:0] raw1_reg;
	logic [HALF_W-1:0] raw1_next;
	logic [SCAN_LEN-1:0] scan_reg;
	logic [SCAN_LEN-1:0] scan_next;
	logic [2:0] mode_reg;
	logic [2:0] mode_next;

	// input selection: normal or self-test set
	always_comb begin
		test_sel = link.test_mode;
		if (test_sel) begin
			eff_enable = link.bist_enable;
		end else begin
			eff_enable = link.enable;
		end
		if (test_sel) begin
			b1_addr = link.bist_addr;
			b0_addr = link.bist_addr;
			odd_word = link.bist_addr[SWAP_BIT];
			wword = link.bist_wdata;
			lanes = link.bist_we;
		end else begin
			b1_addr = link.word_addr;
			b0_addr = {link.word_addr[ADDR_HI:B0_KEEP_LO],
				link.bank0_low};
			odd_word = link.word_addr[ADDR_LO];
			wword = link.wdata;
			lanes = link.lane_we;
		end
	end

	// way held by each bank follows the word parity
	always_comb begin
		b0_way = odd_word;
		b1_way = ~odd_word;
		b0_set_on = link.set_choose[b0_way];
		b1_set_on = link.set_choose[b1_way];
		b0_we = '0;
		b1_we = '0;
		if (eff_enable) begin
			// a disabled array must not be written either
			b0_we = lanes & {LANES{b0_set_on}};
			b1_we = lanes & {LANES{b1_set_on}};
		end
	end

	dcr_bank u_bank0 (
		.aclk(aclk),
		.wr_lanes(b0_we),
		.addr(b0_addr),
		.wdata(wword[HALF_W-1:0]),
		.rdata(b0_rd)
	);

	dcr_bank u_bank1 (
		.aclk(aclk),
		.wr_lanes(b1_we),
		.addr(b1_addr),
		.wdata(wword[WORD_W-1:HALF_W]),
		.rdata(b1_rd)
	);

	// swap mux: on odd words bank 0 holds set 1
	always_comb begin
		if (odd_word) begin
			set1_word = b0_rd;
			set0_word = b1_rd;
		end else begin
			set1_word = b1_rd;
			set0_word = b0_rd;
		end
	end

	// output data: hold while disabled, bypass wins
	always_comb begin
		rd_out_next = rd_out_reg;
		raw0_next = raw0_reg;
		raw1_next = raw1_reg;
		if (eff_enable) begin
			raw0_next = b0_rd;
			raw1_next = b1_rd;
			// read-first: a word written at this edge shows one edge later
			rd_out_next = {set1_word, set0_word};
			rd_out_next = {set1_word, set0_word};
		end
		if (link.bypass) begin
			// raw outputs stay on array data, only the set port is bypassed
			rd_out_next = wword;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_out_reg <= '0;
			raw0_reg <= '0;
			raw1_reg <= '0;
		end else begin
			rd_out_reg <= rd_out_next;
			raw0_reg <= raw0_next;
			raw1_reg <= raw1_next;
		end
	end

	// capture word: the control picture of this edge, msb first
	always_comb begin
		scan_cap = {
			eff_enable,
			test_sel,
			link.bypass,
			odd_word,
			link.set_choose,
			|b0_we,
			|b1_we
		};
	end

	// scan: captures the live control picture, shifts when asked
	always_comb begin
		if (link.scan_shift_control) begin
			scan_next = {scan_reg[SCAN_LEN-2:0], link.scan_in};
		end else begin
			scan_next = scan_cap;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_reg <= '0;
		end else begin
			scan_reg <= scan_next;
		end
	end

	// user-side status flags; they lag the pins by one edge
	always_comb begin
		mode_next = {
			link.bypass,
			test_sel,
			eff_enable
		};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= '0;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign link.rd_data = rd_out_reg;
	assign link.lane0_raw_read = raw0_reg;
	assign link.lane1_raw_read = raw1_reg;
	assign link.scan_out = scan_reg[SCAN_LEN-1];
	assign array_active = mode_reg[0];
	assign selftest_active = mode_reg[1];
	assign bypass_active = mode_reg[2];
endmodule : dcr_data_ram
`default_nettype wire
